/* src/mrh_params.svh */
// Purpose: Constants for the microcode readback host port
// Assumes: 100 MHz ref_clk_i
// Notes:   Offsets are indirect register addresses on the host port
`ifndef MRH_PARAMS_SVH
`define MRH_PARAMS_SVH
`define MRH_SEL_ADDR        2'h0
`define MRH_SEL_DATA        2'h1
`define MRH_SEL_FIFO        2'h2
`define MRH_SEL_STAT        2'h3
`define MRH_REG_CLR_RESET   8'h7F
`define MRH_REG_PRAM_RD     8'h8E
`define MRH_REG_IRQ_EN      8'hC1
`define MRH_SLOW_TOP        8'h8F
`define MRH_IRQ_EN_RST      8'h00
`define MRH_BIT_CC          0
`define MRH_LAT_US          64
`define MRH_CLK_MHZ         100
`define MRH_LAT_CYC         (`MRH_LAT_US * `MRH_CLK_MHZ)
`define MRH_PRAM_AW         10
`endif

/* src/mrh_pkg.sv */
// Purpose: Types for the microcode readback host port
// Assumes: Included constants header
// Notes:   Bus request travels as one struct
package mrh_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } mrh_req_t;
  typedef enum logic [1:0] {MRH_IDLE, MRH_WAIT, MRH_DONE} mrh_state_t;
endpackage

/* src/mrh_pram.sv */
// Purpose: Program RAM with registered read data
// Assumes: Single clock, synchronous read
// Notes:   Write port serves the microcontroller side
`timescale 1ns/100ps
module mrh_pram #(
  parameter int AW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [2**AW];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

/* src/mrh_top.sv */
// How it works
// - Data-step read after selecting 8E returns a program RAM byte.
// - Readback address load resets microcontroller, zeroes its counter, keeps it reset.
// - Host writes 7F after readback; microcontroller then leaves reset and runs.
// - Any byte written to 7F releases the reset; value ignored.
// - Cycle-complete enable in C1 raises a host interrupt on completion.
// - Indirect access is address write on select 00, then data on 01.
// - Lower-range indirect reads take up to 64 us between address and data.
// - Writing one to a status bit clears that set condition.
//
// Purpose: Host-port indirect access with microcode readback from program RAM
// Assumes: Host strobes are synchronous one-cycle pulses
// Notes:   Readback pointer advances per byte; host must readdress each read
`timescale 1ns/100ps
`include "mrh_params.svh"
module mrh_top
  import mrh_pkg::*;
#(
  parameter int LAT_CYC = `MRH_LAT_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        host_wr_i,
  input  wire logic        host_rd_i,
  input  wire logic [1:0]  host_sel_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic      [7:0]  host_rdata_o,
  output logic             host_irq_o,
  input  wire logic        pram_we_i,
  input  wire logic [9:0]  pram_waddr_i,
  input  wire logic [7:0]  pram_wdata_i,
  output logic             mcu_reset_o,
  output logic      [9:0]  mcu_pc_o
);
  // ****************************************
  // Reset synchroniser
  // ****************************************
  // Release is delayed two edges so every state register leaves reset on the same edge
  logic rst_m_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // ****************************************
  // Host request
  // ****************************************
  // Strobes are one-cycle pulses, so each decode below fires once per access
  mrh_req_t req;
  assign req = '{wr: host_wr_i, rd: host_rd_i, sel: host_sel_i, wdata: host_wdata_i};

  // ****************************************
  // Indirect access state
  // ****************************************
  mrh_state_t st_q, st_d;
  logic [7:0]  iaddr_q, iaddr_d;
  logic [12:0] cnt_q, cnt_d;
  logic [9:0]  rdptr_q, rdptr_d;
  logic        hold_q, hold_d;
  logic        cc_q, cc_d;
  logic [7:0]  ien_q, ien_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [7:0]  latch_q, latch_d;
  logic [9:0]  pc_q, pc_d;
  logic [7:0]  pram_rdata;
  logic        pram_re;

  logic addr_wr;
  logic data_wr;
  logic data_rd;
  logic stat_wr;
  logic slow;
  assign addr_wr = req.wr && req.sel == `MRH_SEL_ADDR;
  assign data_wr = req.wr && req.sel == `MRH_SEL_DATA;
  assign data_rd = req.rd && req.sel == `MRH_SEL_DATA;
  assign stat_wr = req.wr && req.sel == `MRH_SEL_STAT;
  assign slow    = req.wdata <= `MRH_SLOW_TOP;
  // Fetch in the last wait cycle so the byte stands ready in the done cycle
  assign pram_re = st_q == MRH_WAIT && cnt_q == 13'h0000 && iaddr_q == `MRH_REG_PRAM_RD;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_d    = st_q;
    iaddr_d = iaddr_q;
    cnt_d   = cnt_q;
    rdptr_d = rdptr_q;
    hold_d  = hold_q;
    cc_d    = cc_q;
    ien_d   = ien_q;
    latch_d = latch_q;
    if (addr_wr) begin
      iaddr_d = req.wdata;
      // The hold outlives the wait: only a clear-reset write lets the core run
      if (req.wdata == `MRH_REG_PRAM_RD) begin
        hold_d = 1'b1;
      end
      // Worst-case latency is always spent; the host never sees an early finish
      if (slow) begin
        st_d  = MRH_WAIT;
        cnt_d = 13'(LAT_CYC - 1);
      end
    end
    if (data_wr) begin
      // For 7F the written byte itself is never looked at; C1 stores it
      if (iaddr_q == `MRH_REG_CLR_RESET) begin
        hold_d  = 1'b0;
        rdptr_d = 10'h000;
      end
      if (iaddr_q == `MRH_REG_IRQ_EN) begin
        ien_d = req.wdata;
      end
    end
    unique case (st_q)
      MRH_IDLE: ;
      // A further address load restarts or freezes the count
      MRH_WAIT: begin
        if (!addr_wr) begin
          if (cnt_q != 13'h0000) begin
            cnt_d = cnt_q - 13'h0001;
          end else begin
            st_d = MRH_DONE;
          end
        end
      end
      MRH_DONE: begin
        if (!addr_wr) begin
          cc_d = 1'b1;
          st_d = MRH_IDLE;
          // Pointer steps only on a finished fetch, so a cut wait re-reads the byte
          if (iaddr_q == `MRH_REG_PRAM_RD) begin
            latch_d = pram_rdata;
            rdptr_d = rdptr_q + 10'h001;
          end
        end
      end
      default: st_d = MRH_IDLE;
    endcase
    // Set beats clear when completion lands on the clearing write
    if (stat_wr && req.wdata[`MRH_BIT_CC] && !(st_q == MRH_DONE && !addr_wr)) begin
      cc_d = 1'b0;
    end
    // Read data are registered and stand until the next read strobe
    rdata_d = rdata_q;
    if (req.rd) begin
      unique case (req.sel)
        `MRH_SEL_ADDR: rdata_d = iaddr_q;
        `MRH_SEL_DATA: rdata_d = iaddr_q == `MRH_REG_PRAM_RD ? latch_q :
                                 iaddr_q == `MRH_REG_IRQ_EN  ? ien_q : 8'h00;
        `MRH_SEL_FIFO: rdata_d = 8'h00;
        `MRH_SEL_STAT: rdata_d = {7'h00, cc_q};
      endcase
    end
    pc_d = hold_d ? 10'h000 : rdptr_d;
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q    <= MRH_IDLE;
      iaddr_q <= 8'h00;
      cnt_q   <= 13'h0000;
      rdptr_q <= 10'h000;
      hold_q  <= 1'b0;
      cc_q    <= 1'b0;
      ien_q   <= `MRH_IRQ_EN_RST;
      rdata_q <= 8'h00;
      latch_q <= 8'h00;
      pc_q    <= 10'h000;
    end else begin
      st_q    <= st_d;
      iaddr_q <= iaddr_d;
      cnt_q   <= cnt_d;
      rdptr_q <= rdptr_d;
      hold_q  <= hold_d;
      cc_q    <= cc_d;
      ien_q   <= ien_d;
      rdata_q <= rdata_d;
      latch_q <= latch_d;
      pc_q    <= pc_d;
    end
  end

  // ****************************************
  // Program RAM
  // ****************************************
  mrh_pram #(
    .AW (`MRH_PRAM_AW)
  ) u_pram (
    .clk_i   (ref_clk_i),
    .we_i    (pram_we_i),
    .waddr_i (pram_waddr_i),
    .wdata_i (pram_wdata_i),
    .re_i    (pram_re),
    .raddr_i (rdptr_q),
    .rdata_o (pram_rdata)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign host_rdata_o = rdata_q;
  assign host_irq_o   = cc_q && ien_q[`MRH_BIT_CC];
  assign mcu_reset_o  = hold_q;
  // Counter parked at zero while held; registered so it never glitches
  assign mcu_pc_o     = pc_q;
endmodule

/* tb/mrh_top_sva.sv */
// Purpose: Port assertions for mrh_top
// Assumes: LAT_CYC as bound
// Notes:   Mirrors indirect address and enable
`timescale 1ns/100ps
module mrh_chk #(parameter int LAT_CYC = 4) (
  input logic       ref_clk_i,
  input logic       rstn_i,
  input logic       host_wr_i,
  input logic       host_rd_i,
  input logic [1:0] host_sel_i,
  input logic [7:0] host_wdata_i,
  input logic [7:0] host_rdata_o,
  input logic       host_irq_o,
  input logic       mcu_reset_o,
  input logic [9:0] mcu_pc_o
);
  localparam int CCD = LAT_CYC + 2;
  logic [7:0] a_q, en_q;
  // Cycles left to the completion edge; a status clear may not win on the last one
  logic [15:0] wc_q;
  wire aw = host_wr_i & host_sel_i == 2'h0;
  wire dw = host_wr_i & host_sel_i == 2'h1;
  wire rel = dw & a_q == 8'h7F;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_q <= 8'h00;
      en_q <= 8'h00;
      wc_q <= 16'h0000;
    end else begin
      a_q <= aw ? host_wdata_i : a_q;
      en_q <= dw & a_q == 8'hC1 ? host_wdata_i : en_q;
      if (aw & (host_wdata_i <= 8'h8F)) begin
        wc_q <= 16'(LAT_CYC + 1);
      end else if (!aw & (wc_q != 16'h0000)) begin
        wc_q <= wc_q - 16'h0001;
      end
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_load_hold: assert property (aw & host_wdata_i == 8'h8E |=> mcu_reset_o)
    else $error("no hold");
  chk_pc_zero: assert property (mcu_reset_o |-> mcu_pc_o == 10'h0)
    else $error("pc moved");
  chk_hold_keep: assert property (mcu_reset_o & !rel |=> mcu_reset_o)
    else $error("hold lost");
  chk_release_any: assert property (rel |=> !mcu_reset_o && mcu_pc_o == 10'h0)
    else $error("no release");
  chk_irq_mask: assert property (host_irq_o |-> en_q[0])
    else $error("irq unmasked");
  chk_cc_time: assert property (aw & host_wdata_i <= 8'h8F & en_q[0] |-> ##[1:CCD] host_irq_o)
    else $error("irq late");
  chk_cc_clear: assert property (
    host_irq_o & host_wr_i & host_sel_i == 2'h3 & host_wdata_i[0] & wc_q != 16'h0001
    |=> !host_irq_o)
    else $error("not cleared");
  chk_rd_hold: assert property (!host_rd_i |=> $stable(host_rdata_o))
    else $error("rdata moved");
  cover property (rel);
  cover property ($rose(host_irq_o));
  cover property (host_rd_i & mcu_reset_o);
  cover property (host_irq_o & host_wr_i & host_sel_i == 2'h3);
endmodule
bind mrh_top mrh_chk #(.LAT_CYC(LAT_CYC)) chk_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_sel_i(host_sel_i),
  .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_irq_o(host_irq_o),
  .mcu_reset_o(mcu_reset_o), .mcu_pc_o(mcu_pc_o));

/* tb/mrh_host.sv */
// Purpose: Host processor on the byte port
// Assumes: Strobes launched after a rising edge
// Notes:   Released data inverted, never stale
`timescale 1ns/100ps
module mrh_host
  import mrh_pkg::*;
(
  input  logic       clk_i,
  input  logic [7:0] rdata_i,
  output mrh_req_t   req_o
);
  initial req_o = '0;
  task automatic put(input logic [1:0] s, input logic [7:0] d, input logic w = 1'b1);
    @(posedge clk_i);
    req_o <= '{w, !w, s, d};
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b0, s, ~d};
  endtask
  task automatic get(input logic [1:0] s, output logic [7:0] d);
    put(s, 8'h00, 1'b0);
    @(posedge clk_i);
    d = rdata_i;
  endtask
  // Early data reads return the previously latched byte, so poll completion first
  task automatic load(input logic [7:0] a, output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    put(2'h0, a);
    for (int i = 0; i < 20 && !ok; i++) begin
      get(2'h3, s);
      ok = s[0];
    end
  endtask
endmodule

/* tb/tb_microcode_readback_host_access.sv */
// Purpose: Bench for readback over the host port
// Assumes: Latency cut to 4 cycles
// Notes:   Host model makes every bus cycle
`timescale 1ns/100ps
module tb_microcode_readback_host_access
  import mrh_pkg::*;
;
  logic       clk, rstn, we, irq, hold, ok;
  logic [9:0] wa, pc;
  logic [7:0] wd, rdat, got;
  mrh_req_t   req;
  int         n_errors, n_compared;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  mrh_host host_u (.clk_i(clk), .rdata_i(rdat), .req_o(req));
  mrh_top #(.LAT_CYC(4)) dut_u (.ref_clk_i(clk), .rstn_i(rstn), .host_wr_i(req.wr),
    .host_rd_i(req.rd), .host_sel_i(req.sel), .host_wdata_i(req.wdata), .host_rdata_o(rdat),
    .host_irq_o(irq), .pram_we_i(we), .pram_waddr_i(wa), .pram_wdata_i(wd),
    .mcu_reset_o(hold), .mcu_pc_o(pc));
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    we = 1'b0;
    wa = 10'h0;
    wd = 8'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      we <= 1'b1;
      wa <= 10'(i);
      wd <= 8'h3C + 8'(i * 17);
      @(posedge clk);
    end
    we <= 1'b0;
    for (int n = 0; n < 3; n++) begin
      host_u.load(8'h8E, ok);
      chk(10'(ok), 10'h1);
      if (ok !== 1'b1) finish_test();
      chk(10'(hold), 10'h1);
      chk(pc, 10'h000);
      host_u.put(2'h3, 8'h01);
      host_u.get(2'h3, got);
      chk(10'(got), 10'h000);
      host_u.get(2'h1, got);
      chk(10'(got), 10'(8'h3C + 8'(n * 17)));
    end
    host_u.put(2'h0, 8'hC1);
    host_u.put(2'h1, 8'h01);
    host_u.get(2'h1, got);
    chk(10'(got), 10'h001);
    host_u.put(2'h0, 8'h8E);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
    chk(10'(irq), 10'h1);
    if (irq !== 1'b1) finish_test();
    host_u.put(2'h3, 8'h01);
    host_u.get(2'h1, got);
    chk(10'(got), 10'h6F);
    host_u.put(2'h0, 8'h7F);
    host_u.put(2'h1, 8'hA5);
    @(posedge clk);
    chk(10'(hold), 10'h0);
    chk(pc, 10'h000);
    finish_test();
  end
endmodule
